// [shared/pcs_defines.vh]
/*
 Constants for the power-module command decoder: command codes,
 field positions, reset values, value limits and timing counts.
 Assumes inclusion by bare name from the design file.
*/
`ifndef PCS_DEFINES_VH
`define PCS_DEFINES_VH

// Command codes
`define PCS_CMD_ON_OFF 8'h01
`define PCS_CMD_ENCFG 8'h02
`define PCS_CMD_CLEAR 8'h03
`define PCS_CMD_STORE 8'h11
`define PCS_CMD_VFMT 8'h20
`define PCS_CMD_VSET 8'h21
`define PCS_CMD_VTRIM 8'h23
`define PCS_CMD_MHI 8'h25
`define PCS_CMD_MLO 8'h26
`define PCS_CMD_DROOP 8'h28
`define PCS_CMD_INPUT_TURN_ON_LEVEL 8'h35
`define PCS_CMD_INPUT_TURN_OFF_LEVEL 8'h36
`define PCS_CMD_OV_LIM 8'h40
`define PCS_CMD_OV_RSP 8'h41
`define PCS_CMD_OC_LIM 8'h46
`define PCS_CMD_OC_RSP 8'h47
`define PCS_CMD_OCW_LIM 8'h4A
`define PCS_CMD_OT_LIM 8'h4F

// Writable masks and reset values of bit-field commands
`define PCS_ON_OFF_WMASK 8'hB0
`define PCS_ON_OFF_RST 8'h88
`define PCS_ENCFG_WMASK 8'h04
`define PCS_ENCFG_RST 8'h1D
`define PCS_ENCFG_POL_BIT 1
`define PCS_RSP_WMASK 8'h38
`define PCS_OV_RSP_RST 8'hB8
`define PCS_OC_RSP_RST 8'hF8
`define PCS_VFMT_VAL 8'h14
`define PCS_MARGIN_RSVD 2'h3

// Voltage settings, 1/4096 V per count
`define PCS_VSET_RST 16'hC000
`define PCS_VSET_MAX 16'hC000
`define PCS_VSET_MIN 16'h9800
`define PCS_TRIM_MAX 16'h0400
`define PCS_TRIM_MIN 16'hFC00
`define PCS_TRIM_RST 16'h0000
`define PCS_MARGIN_MAX 16'hD333
`define PCS_MARGIN_MIN 16'h819A
`define PCS_MHI_RST 16'hC99A
`define PCS_MLO_RST 16'hB666
`define PCS_OV_MAX 16'hFFD7
`define PCS_OV_MIN 16'hAE67
`define PCS_OV_RST 16'hE000
`define PCS_OV_HEADROOM 16'h3000

// Droop in 0.1 mV/A, input levels in V, current in A, temp in C
`define PCS_DROOP_MAX 16'h01F4
`define PCS_DROOP_RST 16'h0000
`define PCS_VIN_MAX 16'h002E
`define PCS_VIN_MIN 16'h0028
`define PCS_VIN_HYST 16'h0002
`define PCS_INPUT_TURN_ON_LEVEL_RST 16'h002C
`define PCS_INPUT_TURN_OFF_LEVEL_RST 16'h002A
`define PCS_OC_MAX 16'h0064
`define PCS_OC_MIN 16'h0022
`define PCS_OC_RST 16'h0050
`define PCS_OCW_MAX 16'h005A
`define PCS_OCW_MIN 16'h0019
`define PCS_OCW_RST 16'h0046
`define PCS_OT_MAX 16'h008C
`define PCS_OT_MIN 16'h0019
`define PCS_OT_RST 16'h0082

// Status byte bits
`define PCS_CML_CMD_BIT 7
`define PCS_CML_DATA_BIT 6
`define PCS_CML_PEC_BIT 5

// Store time
`define PCS_CLK_HZ 50000000
`define PCS_STORE_MS 500
`define PCS_STORE_CYC (`PCS_STORE_MS * (`PCS_CLK_HZ / 1000))
`define PCS_NV_WORDS 16

`endif

// [hdl/pcs_command_set.v]
/*
 Command decoder and setting store of a power module's management
 port: checks and stores the settings, reports rejected traffic,
 drives the run decision and keeps a nonvolatile copy on request.
 Assumes a frame layer on the same clock that delivers one decoded
 command per cmd_valid pulse and reports packet check failures.
*/
`include "pcs_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module pcs_command_set #(
    parameter STORE_CYCLES = `PCS_STORE_CYC
) (
    // Clock and reset
    input wire clock,
    input wire rst_b,
    // Decoded command from the frame layer
    input wire cmd_valid,
    input wire cmd_write,
    input wire [7:0] cmd_code,
    input wire [15:0] cmd_wdata,
    input wire pec_error,
    output reg rd_valid,
    output reg [15:0] rd_data,
    // Module pins and strap
    input wire enable_pin,
    input wire polarity_strap,
    input wire trim_lock,
    // Fault conditions from protection logic
    input wire ov_fault,
    input wire oc_fault,
    input wire ot_fault,
    input wire [15:0] ot_warn_limit,
    // Results
    output reg [7:0] cml_status,
    output reg run,
    output reg [15:0] vout_target,
    output reg [15:0] ov_limit_eff,
    output reg store_busy,
    // Nonvolatile copy readout
    input wire [3:0] nv_index,
    output reg [15:0] nv_data
);

    localparam ST_IDLE = 1'b0;
    localparam ST_STORE = 1'b1;

    reg [7:0] on_off_control;
    reg [7:0] enable_configuration;
    reg [15:0] output_voltage_setpoint;
    reg [15:0] output_voltage_trim;
    reg [15:0] margin_high_voltage;
    reg [15:0] margin_low_voltage;
    reg [15:0] load_line_droop;
    reg [15:0] input_turn_on_level;
    reg [15:0] input_turn_off_level;
    reg [15:0] output_overvoltage_limit;
    reg [7:0] output_overvoltage_reaction;
    reg [15:0] overcurrent_fault_limit;
    reg [7:0] overcurrent_reaction;
    reg [15:0] overcurrent_warning_limit;
    reg [15:0] overtemperature_fault_limit;
    reg [15:0] nv_mem [0:`PCS_NV_WORDS-1];
    reg state;
    reg [24:0] store_count;
    reg strap_taken;
    reg [1:0] pin_sync;
    reg [1:0] strap_sync;
    reg latched_off;
    reg prev_on;

    wire wr = cmd_valid & cmd_write & (state == ST_IDLE);
    wire rd = cmd_valid & ~cmd_write & (state == ST_IDLE);
    wire [7:0] wbyte = cmd_wdata[7:0];
    wire [15:0] w = cmd_wdata;
    wire signed [15:0] ws = cmd_wdata;
    wire [2:0] retry = wbyte[5:3];
    wire retry_ok = (retry == 3'h0) | (retry == 3'h7);

    // Validity of each command code and its data
    reg known;
    reg data_ok;
    reg ro_cmd;
    reg [15:0] rd_mux;
    always @* begin
        known = 1'b1;
        data_ok = 1'b1;
        ro_cmd = 1'b0;
        rd_mux = 16'h0000;
        case (cmd_code)
            `PCS_CMD_ON_OFF: begin
                rd_mux = {8'h00, on_off_control};
                // Margin code 11 is reserved, only plain margins
                data_ok = wbyte[5:4] != `PCS_MARGIN_RSVD;
            end
            `PCS_CMD_ENCFG: rd_mux = {8'h00, enable_configuration};
            `PCS_CMD_CLEAR: rd_mux = 16'h0000;
            `PCS_CMD_STORE: rd_mux = 16'h0000;
            `PCS_CMD_VFMT: begin
                rd_mux = {8'h00, `PCS_VFMT_VAL};
                ro_cmd = 1'b1;
            end
            `PCS_CMD_VSET: begin
                rd_mux = output_voltage_setpoint;
                data_ok = (w >= `PCS_VSET_MIN) &
                    (w <= `PCS_VSET_MAX);
            end
            `PCS_CMD_VTRIM: begin
                rd_mux = output_voltage_trim;
                data_ok = (ws >= $signed(`PCS_TRIM_MIN)) &
                    (ws <= $signed(`PCS_TRIM_MAX));
                ro_cmd = trim_lock;
            end
            `PCS_CMD_MHI: begin
                rd_mux = margin_high_voltage;
                data_ok = (w >= `PCS_MARGIN_MIN) &
                    (w <= `PCS_MARGIN_MAX) &
                    (w > margin_low_voltage);
            end
            `PCS_CMD_MLO: begin
                rd_mux = margin_low_voltage;
                data_ok = (w >= `PCS_MARGIN_MIN) &
                    (w <= `PCS_MARGIN_MAX) &
                    (w < margin_high_voltage);
            end
            `PCS_CMD_DROOP: begin
                rd_mux = load_line_droop;
                data_ok = w <= `PCS_DROOP_MAX;
            end
            `PCS_CMD_INPUT_TURN_ON_LEVEL: begin
                rd_mux = input_turn_on_level;
                // Off stays below on by the gap
                data_ok = (w >= `PCS_VIN_MIN) & (w <= `PCS_VIN_MAX) &
                    (w >= input_turn_off_level + `PCS_VIN_HYST);
            end
            `PCS_CMD_INPUT_TURN_OFF_LEVEL: begin
                rd_mux = input_turn_off_level;
                data_ok = (w >= `PCS_VIN_MIN) & (w <= `PCS_VIN_MAX) &
                    (w + `PCS_VIN_HYST <= input_turn_on_level);
            end
            `PCS_CMD_OV_LIM: begin
                rd_mux = output_overvoltage_limit;
                data_ok = (w >= `PCS_OV_MIN) & (w <= `PCS_OV_MAX) &
                    (w > output_voltage_setpoint);
            end
            `PCS_CMD_OV_RSP: begin
                rd_mux = {8'h00, output_overvoltage_reaction};
                data_ok = retry_ok;
            end
            `PCS_CMD_OC_LIM: begin
                rd_mux = overcurrent_fault_limit;
                data_ok = (w >= `PCS_OC_MIN) & (w <= `PCS_OC_MAX) &
                    (w > overcurrent_warning_limit);
            end
            `PCS_CMD_OC_RSP: begin
                rd_mux = {8'h00, overcurrent_reaction};
                data_ok = retry_ok;
            end
            `PCS_CMD_OCW_LIM: begin
                rd_mux = overcurrent_warning_limit;
                data_ok = (w >= `PCS_OCW_MIN) & (w <= `PCS_OCW_MAX) &
                    (w < overcurrent_fault_limit);
            end
            `PCS_CMD_OT_LIM: begin
                rd_mux = overtemperature_fault_limit;
                data_ok = (w >= `PCS_OT_MIN) & (w <= `PCS_OT_MAX) &
                    (w > ot_warn_limit);
            end
            default: known = 1'b0;
        endcase
    end

    // Write-only commands have nothing to read back
    wire wo_cmd = (cmd_code == `PCS_CMD_CLEAR) |
        (cmd_code == `PCS_CMD_STORE);
    wire bad_cmd = cmd_valid & (~known | (cmd_write & ro_cmd) |
        (~cmd_write & wo_cmd) | (state == ST_STORE));
    wire bad_data = wr & known & ~ro_cmd & ~data_ok;
    wire accept = wr & known & ~ro_cmd & data_ok;
    wire do_clear = accept & (cmd_code == `PCS_CMD_CLEAR);
    wire do_store = accept & (cmd_code == `PCS_CMD_STORE);

    // Setting store; a rejected value never reaches a register
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            on_off_control <= `PCS_ON_OFF_RST;
            output_voltage_setpoint <= `PCS_VSET_RST;
            output_voltage_trim <= `PCS_TRIM_RST;
            margin_high_voltage <= `PCS_MHI_RST;
            margin_low_voltage <= `PCS_MLO_RST;
            load_line_droop <= `PCS_DROOP_RST;
            input_turn_on_level <= `PCS_INPUT_TURN_ON_LEVEL_RST;
            input_turn_off_level <= `PCS_INPUT_TURN_OFF_LEVEL_RST;
            output_overvoltage_limit <= `PCS_OV_RST;
            output_overvoltage_reaction <= `PCS_OV_RSP_RST;
            overcurrent_fault_limit <= `PCS_OC_RST;
            overcurrent_reaction <= `PCS_OC_RSP_RST;
            overcurrent_warning_limit <= `PCS_OCW_RST;
            overtemperature_fault_limit <= `PCS_OT_RST;
        end else if (accept) begin
            case (cmd_code)
                `PCS_CMD_ON_OFF: on_off_control <=
                    (wbyte & `PCS_ON_OFF_WMASK) |
                    (on_off_control & ~`PCS_ON_OFF_WMASK);
                `PCS_CMD_VSET: output_voltage_setpoint <= w;
                `PCS_CMD_VTRIM: output_voltage_trim <= w;
                `PCS_CMD_MHI: margin_high_voltage <= w;
                `PCS_CMD_MLO: margin_low_voltage <= w;
                `PCS_CMD_DROOP: load_line_droop <= w;
                `PCS_CMD_INPUT_TURN_ON_LEVEL: input_turn_on_level <= w;
                `PCS_CMD_INPUT_TURN_OFF_LEVEL: input_turn_off_level <= w;
                `PCS_CMD_OV_LIM: output_overvoltage_limit <= w;
                `PCS_CMD_OV_RSP: output_overvoltage_reaction <=
                    (wbyte & `PCS_RSP_WMASK) |
                    (`PCS_OV_RSP_RST & ~`PCS_RSP_WMASK);
                `PCS_CMD_OC_LIM: overcurrent_fault_limit <= w;
                `PCS_CMD_OC_RSP: overcurrent_reaction <=
                    (wbyte & `PCS_RSP_WMASK) |
                    (`PCS_OC_RSP_RST & ~`PCS_RSP_WMASK);
                `PCS_CMD_OCW_LIM: overcurrent_warning_limit <= w;
                `PCS_CMD_OT_LIM: overtemperature_fault_limit <= w;
                default: on_off_control <= on_off_control;
            endcase
        end
    end

    // Pin and strap synchronisers, first stage read by second only
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pin_sync <= 2'h0;
            strap_sync <= 2'h0;
        end else begin
            pin_sync <= {pin_sync[0], enable_pin};
            strap_sync <= {strap_sync[0], polarity_strap};
        end
    end

    // Enable config: strap followed every cycle after release, bit 2 writable
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            enable_configuration <= `PCS_ENCFG_RST;
            strap_taken <= 1'b0;
        end else begin
            if (!strap_taken) begin
                // Waits one clock, one short of the synchroniser filling
                strap_taken <= 1'b1;
            end
            if (strap_taken) begin
                enable_configuration[`PCS_ENCFG_POL_BIT] <=
                    strap_sync[1];
            end
            if (accept && cmd_code == `PCS_CMD_ENCFG) begin
                enable_configuration[2] <= wbyte[2];
            end
        end
    end

    // Fault reaction: retry 000 latches off, 111 waits out fault
    wire ov_latch = output_overvoltage_reaction[5:3] == 3'h0;
    wire oc_latch = overcurrent_reaction[5:3] == 3'h0;
    wire on_cmd = on_off_control[7];
    wire pin_on = enable_configuration[`PCS_ENCFG_POL_BIT] ?
        pin_sync[1] : ~pin_sync[1];
    wire want_on = ~enable_configuration[4] |
        ((~enable_configuration[3] | on_cmd) &
        (~enable_configuration[2] | pin_on));
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            latched_off <= 1'b0;
            prev_on <= 1'b0;
        end else begin
            prev_on <= on_cmd;
            // A new fault wins over a clear in the same cycle
            if ((ov_fault & ov_latch) | (oc_fault & oc_latch)) begin
                latched_off <= 1'b1;
            end else if (do_clear | (prev_on & ~on_cmd)) begin
                latched_off <= 1'b0;
            end
        end
    end

    // Run decision and targets; any present fault shuts down
    wire [16:0] ov_cap = {1'b0, output_voltage_setpoint} +
        {1'b0, `PCS_OV_HEADROOM};
    wire [15:0] ov_auto = (ov_cap > {1'b0, `PCS_OV_MAX}) ?
        `PCS_OV_MAX : ov_cap[15:0];
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            run <= 1'b0;
            vout_target <= `PCS_VSET_RST;
            ov_limit_eff <= `PCS_OV_RST;
        end else begin
            run <= want_on & ~latched_off & ~ov_fault & ~oc_fault &
                ~ot_fault;
            case (on_off_control[5:4])
                2'h1: vout_target <= margin_low_voltage;
                2'h2: vout_target <= margin_high_voltage;
                default: vout_target <= output_voltage_setpoint;
            endcase
            // User limit overridden when above setpoint plus headroom
            ov_limit_eff <= (output_overvoltage_limit > ov_auto) ?
                ov_auto : output_overvoltage_limit;
        end
    end

    // Communication status, set wins over clear
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cml_status <= 8'h00;
        end else begin
            if (do_clear) begin
                cml_status <= 8'h00;
            end
            if (bad_cmd) begin
                cml_status[`PCS_CML_CMD_BIT] <= 1'b1;
            end
            if (bad_data) begin
                cml_status[`PCS_CML_DATA_BIT] <= 1'b1;
            end
            if (pec_error) begin
                cml_status[`PCS_CML_PEC_BIT] <= 1'b1;
            end
        end
    end

    // Readback, one cycle after the request
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rd_valid <= 1'b0;
            rd_data <= 16'h0000;
        end else begin
            rd_valid <= rd & known & ~wo_cmd;
            if (rd & known & ~wo_cmd) begin
                rd_data <= rd_mux;
            end
        end
    end

    // Store sequencer; busy for the full write time
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state <= ST_IDLE;
            store_count <= 25'h0000000;
            store_busy <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (do_store) begin
                        state <= ST_STORE;
                        store_busy <= 1'b1;
                        store_count <= STORE_CYCLES[24:0] - 25'h0000001;
                    end
                end
                ST_STORE: begin
                    if (store_count == 25'h0000000) begin
                        state <= ST_IDLE;
                        store_busy <= 1'b0;
                    end else begin
                        store_count <= store_count - 25'h0000001;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Live settings in nonvolatile word order
    wire [15:0] live [0:`PCS_NV_WORDS-1];
    assign live[0] = {on_off_control, enable_configuration};
    assign live[1] = output_voltage_setpoint;
    assign live[2] = output_voltage_trim;
    assign live[3] = margin_high_voltage;
    assign live[4] = margin_low_voltage;
    assign live[5] = load_line_droop;
    assign live[6] = input_turn_on_level;
    assign live[7] = input_turn_off_level;
    assign live[8] = output_overvoltage_limit;
    assign live[9] = {output_overvoltage_reaction, overcurrent_reaction};
    assign live[10] = overcurrent_fault_limit;
    assign live[11] = overcurrent_warning_limit;
    assign live[12] = overtemperature_fault_limit;
    assign live[13] = 16'h0000;
    assign live[14] = 16'h0000;
    assign live[15] = 16'h0000;

    // Copy taken at the store request; no reset, it models memory
    genvar gi;
    generate
        for (gi = 0; gi < `PCS_NV_WORDS; gi = gi + 1) begin : g_nv
            always @(posedge clock) begin
                if (do_store) begin
                    nv_mem[gi] <= live[gi];
                end
            end
        end
    endgenerate

    // Nonvolatile readout port
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            nv_data <= 16'h0000;
        end else begin
            nv_data <= nv_mem[nv_index];
        end
    end

endmodule // pcs_command_set

`default_nettype wire

// [verif/pcs_command_set_chk.sv]
/*
 Port checker for the command decoder: answers, refusals, store timing,
 status flags and fault shutdown.
 Assumes one clock, rst_b low resets, bound to the decoder's top.
*/
`timescale 1ns/1ps
`default_nettype none
module pcs_command_set_chk #(parameter int STORE_CYCLES = 20) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Command side
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    input wire logic pec_error,
    input wire logic ov_fault,
    // Results
    input wire logic rd_valid,
    input wire logic [15:0] rd_data,
    input wire logic [7:0] cml_status,
    input wire logic run,
    input wire logic store_busy
);
    int unsigned busy_cnt;
    // Length of the current busy stretch, for the store timing check
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) busy_cnt <= 0;
        else busy_cnt <= store_busy ? busy_cnt + 1 : 0;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    // A command of one kind issued while no store is busy
    sequence s_take(logic w, logic [7:0] c);
        cmd_valid && cmd_write == w && cmd_code == c && !store_busy;
    endsequence
    sequence s_clear;
        cmd_valid && cmd_write && cmd_code == 8'h03;
    endsequence
    AST_FMT_READ: assert property (s_take(1'b0, 8'h20) |=> rd_valid && rd_data == 16'h0014)
        else $error("format byte read wrong");
    AST_FMT_RO: assert property (s_take(1'b1, 8'h20) |=> cml_status[7])
        else $error("format byte write not refused");
    AST_VSET_RANGE: assert property (s_take(1'b1, 8'h21) ##0
        (cmd_wdata > 16'hC000 || cmd_wdata < 16'h9800) |=> cml_status[6])
        else $error("setpoint out of range accepted");
    AST_STORE_START: assert property (s_take(1'b1, 8'h11) |=> store_busy)
        else $error("store did not start");
    AST_STORE_LEN: assert property ($fell(store_busy) |-> busy_cnt == STORE_CYCLES)
        else $error("store busy length wrong");
    AST_BUSY_REFUSE: assert property (store_busy && cmd_valid |=> cml_status[7])
        else $error("command during store not refused");
    AST_PEC: assert property (pec_error |=> cml_status[5])
        else $error("check failure flag not set");
    AST_CML_HOLD: assert property (cml_status[6] &&
        !(cmd_valid && cmd_write && cmd_code == 8'h03) |=> cml_status[6])
        else $error("data flag lost without clear");
    AST_CLEAR: assert property (s_clear ##0 !store_busy && !pec_error |=> cml_status == 8'h00)
        else $error("status not cleared");
    AST_OV_OFF: assert property (ov_fault |=> !run)
        else $error("overvoltage did not stop output");
endmodule // pcs_command_set_chk
bind pcs_command_set pcs_command_set_chk #(.STORE_CYCLES(STORE_CYCLES)) i_chk (
    .clock, .rst_b, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata, .pec_error,
    .ov_fault, .rd_valid, .rd_data, .cml_status, .run, .store_busy);
`default_nettype wire

// [verif/pcs_host.sv]
/*
 Host model of the management bus side: issues one command at a time.
 Assumes the decoder's clock and its one-cycle command pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module pcs_host (
    // Clock and decoder status
    input wire logic clock,
    input wire logic store_busy,
    input wire logic rd_valid,
    input wire logic [15:0] rd_data,
    // Command outputs
    output logic cmd_valid,
    output logic cmd_write,
    output logic [7:0] cmd_code,
    output logic [15:0] cmd_wdata
);
    logic [15:0] got;
    initial cmd_valid = 1'b0;
    initial {cmd_write, cmd_code, cmd_wdata} = 25'h0;
    // One command; rude skips the quiet time that a store demands
    task automatic xfer(input logic w, input logic [7:0] c,
        input logic [15:0] d, input logic rude);
        while (store_busy && !rude) @(posedge clock);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_code <= c;
        cmd_wdata <= d;
        @(posedge clock);
        cmd_valid <= 1'b0;
        cmd_code <= ~c; // Released code and data lines do not keep the last value
        cmd_wdata <= ~d;
        @(posedge clock);
        if (rd_valid === 1'b1) got = rd_data;
    endtask
endmodule // pcs_host
`default_nettype wire

// [verif/test_pcs_command_set.sv]
/*
 Testbench for the command decoder: reset values, ranges, cross-checks,
 bit fields, faults, refusals and store.
 Assumes the decoder and host model compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
module test_pcs_command_set;
    localparam int SC = 20;
    logic clock = 1'b0;
    logic rst_b, pec_error, enable_pin, polarity_strap, trim_lock;
    logic ov_fault, oc_fault, ot_fault, cmd_valid, cmd_write, rd_valid;
    logic run, store_busy;
    logic [7:0] cmd_code, cml_status;
    logic [15:0] cmd_wdata, rd_data, ot_warn_limit, vout_target;
    logic [15:0] ov_limit_eff, nv_data;
    logic [3:0] nv_index;
    int fail_count = 0;
    int n_tests = 0;
    // Range table: code, value after reset, refused value, accepted value
    logic [7:0] codes [11] = '{8'h21, 8'h23, 8'h25, 8'h26, 8'h28, 8'h35,
        8'h36, 8'h40, 8'h46, 8'h4A, 8'h4F};
    logic [15:0] olds [11] = '{16'hC000, 16'h0000, 16'hC99A, 16'hB666,
        16'h0000, 16'h002C, 16'h002A, 16'hE000, 16'h0050, 16'h0046, 16'h0082};
    logic [15:0] bads [11] = '{16'hC001, 16'h0401, 16'hD334, 16'hD333,
        16'h01F5, 16'h002F, 16'h002D, 16'hFFD8, 16'h0065, 16'h0064, 16'h0030};
    logic [15:0] goods [11] = '{16'h9800, 16'hFC00, 16'hD333, 16'h819A,
        16'h01F4, 16'h002E, 16'h0028, 16'hAE67, 16'h0064, 16'h0019, 16'h008C};
    always #10 clock = ~clock;
    pcs_command_set #(.STORE_CYCLES(SC)) i_pcs_command_set (
        .clock, .rst_b, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata,
        .pec_error, .rd_valid, .rd_data, .enable_pin, .polarity_strap,
        .trim_lock, .ov_fault, .oc_fault, .ot_fault, .ot_warn_limit,
        .cml_status, .run, .vout_target, .ov_limit_eff, .store_busy,
        .nv_index, .nv_data);
    pcs_host i_pcs_host (.clock, .store_busy, .rd_valid, .rd_data,
        .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata);
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        n_tests++;
        if (seen !== want) begin
            fail_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        i_pcs_host.xfer(1'b1, c, d, 1'b0);
    endtask
    task automatic rd(input logic [7:0] c, input logic [15:0] want);
        i_pcs_host.got = 16'hDEAD; // Stale answer must not pass
        i_pcs_host.xfer(1'b0, c, 16'h0000, 1'b0);
        check(i_pcs_host.got, want);
    endtask
    task automatic close_out;
        $display("mismatches %0d of %0d checks", fail_count, n_tests);
        if (fail_count == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Cut a hang short well past the expected run
    initial begin
        repeat (5000) @(posedge clock);
        fail_count++;
        close_out();
    end
    initial begin
        {rst_b, pec_error, trim_lock, ov_fault, oc_fault, ot_fault} = 6'h00;
        {enable_pin, polarity_strap} = 2'h3;
        ot_warn_limit = 16'h0030;
        nv_index = 4'h0;
        repeat (10) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        rd(8'h01, 16'h0088);
        rd(8'h02, 16'h001F);
        rd(8'h20, 16'h0014);
        rd(8'h21, 16'hC000);
        rd(8'h41, 16'h00B8);
        rd(8'h47, 16'h00F8);
        // Refused value keeps the old one, accepted value is stored
        for (int k = 0; k < 11; k++) begin
            wr(codes[k], bads[k]);
            check(cml_status, 16'h0040);
            rd(codes[k], olds[k]);
            wr(8'h03, 16'h0000);
            wr(codes[k], goods[k]);
            rd(codes[k], goods[k]);
        end
        check(vout_target, 16'h9800);
        wr(8'h40, 16'hFFD7);
        repeat (2) @(posedge clock);
        check(ov_limit_eff, 16'hC800);
        wr(8'h01, 16'h00EF);
        rd(8'h01, 16'h00A8);
        check(vout_target, 16'hD333);
        wr(8'h01, 16'h0030);
        check(cml_status, 16'h0040);
        wr(8'h03, 16'h0000);
        // Pin released: with bit 2 set the output must stop
        enable_pin <= 1'b0;
        repeat (4) @(posedge clock);
        check(run, 16'h0000);
        enable_pin <= 1'b1;
        wr(8'h02, 16'h0000);
        rd(8'h02, 16'h001B);
        wr(8'h41, 16'h0000);
        rd(8'h41, 16'h0080);
        wr(8'h41, 16'h0028);
        check(cml_status, 16'h0040);
        wr(8'h03, 16'h0000);
        wr(8'h47, 16'h0000);
        rd(8'h47, 16'h00C0);
        check(run, 16'h0001);
        // Retry 000 stays off until cleared, 111 comes back alone
        ov_fault <= 1'b1;
        @(posedge clock);
        ov_fault <= 1'b0;
        repeat (4) @(posedge clock);
        check(run, 16'h0000);
        wr(8'h03, 16'h0000);
        repeat (4) @(posedge clock);
        check(run, 16'h0001);
        wr(8'h47, 16'h0038);
        oc_fault <= 1'b1;
        repeat (2) @(posedge clock);
        check(run, 16'h0000);
        oc_fault <= 1'b0;
        repeat (6) @(posedge clock);
        check(run, 16'h0001);
        // Temperature fault stops the output while present, then restarts
        ot_fault <= 1'b1;
        repeat (2) @(posedge clock);
        check(run, 16'h0000);
        ot_fault <= 1'b0;
        repeat (3) @(posedge clock);
        check(run, 16'h0001);
        // Unknown code, locked trim and check failure
        i_pcs_host.xfer(1'b0, 8'h50, 16'h0000, 1'b0);
        check(cml_status, 16'h0080);
        wr(8'h03, 16'h0000);
        trim_lock <= 1'b1;
        wr(8'h23, 16'h0100);
        check(cml_status, 16'h0080);
        trim_lock <= 1'b0;
        pec_error <= 1'b1;
        @(posedge clock);
        pec_error <= 1'b0;
        @(posedge clock);
        check(cml_status, 16'h00A0);
        wr(8'h03, 16'h0000);
        // Store, a command pushed in while busy, then the copy
        wr(8'h11, 16'h0000);
        check(store_busy, 16'h0001);
        i_pcs_host.xfer(1'b1, 8'h21, 16'hA000, 1'b1);
        check(cml_status, 16'h0080);
        rd(8'h21, 16'h9800);
        nv_index <= 4'h1;
        repeat (2) @(posedge clock);
        check(nv_data, 16'h9800);
        close_out();
    end
endmodule // test_pcs_command_set
`default_nettype wire
